// File: logic/rx_router_regs.svh
`ifndef RX_ROUTER_REGS_SVH
`define RX_ROUTER_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_ISO_TRAILER 12'h144
`define OFS_ROUTE_CTRL 12'h148
`define OFS_THR_LO 12'h180
`define OFS_THR_HI 12'h184
`define OFS_IRQ_STATUS 12'h190
`define OFS_IRQ_CLEAR 12'h194
`define OFS_IRQ_ENABLE 12'h198
// ----------------------------------------------------------------
// field positions (bit 0 of the quadlet is its msb, so doc bit n is 31-n)
// ----------------------------------------------------------------
`define POS_SPEED 16
`define POS_PAD 8
`define POS_ACK 0
`define POS_FP_RESTART 16
`define POS_ACK_PEND 14
`define POS_CONT_OFF 12
`define POS_RESP_DEST 11
`define POS_SELFID_DEST 10
`define POS_ASYNC_LO 9
`define POS_ASYNC_HI 8
// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define ISO_TRAILER_MASK 32'h0003_030F
`define ROUTE_CTRL_RMASK 32'h0001_4F00
`define ROUTE_CTRL_RESET 32'h0000_4400
`define IRQ_BITS 3
`define IRQ_EV_TRAILER 0
`define IRQ_EV_DATA_ERR 1
`define IRQ_EV_DV_RESET 2
// ----------------------------------------------------------------
// acknowledge codes
// ----------------------------------------------------------------
`define ACK_COMPLETE 4'h1
`define ACK_PENDING 4'h2
`define ACK_DATA_ERROR 4'hD
// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: logic/rx_router_pkg.sv
package rx_router_pkg;
  // destination receive queue, one-hot
  typedef enum logic [2:0] {
    DEST_ASYNC_CTRL = 3'b001,
    DEST_BROADCAST = 3'b010,
    DEST_BULK_ASYNC = 3'b100
  } dest_e;
  // class of a received packet as the receiver decodes it
  typedef enum logic [2:0] {
    PKT_ASYNC = 3'b001,
    PKT_RESP_MATCH = 3'b010,
    PKT_SELFID = 3'b100
  } pkt_kind_e;
  // packet descriptor from the receiver, one-cycle valid
  typedef struct packed {
    logic valid;
    pkt_kind_e kind;
    logic broadcast;
    logic rom_reg_space;
    logic request;
    logic write_lock;
    logic crc_ok;
    logic [47:0] dest_addr;
  } rx_pkt_s;
  // isochronous trailer from the receive queue control, one-cycle valid
  typedef struct packed {
    logic valid;
    logic [31:0] quadlet;
  } iso_trailer_s;
  // routing / acknowledge answer
  typedef struct packed {
    logic valid;
    dest_e dest;
    logic ack_valid;
    logic [3:0] ack_code;
  } route_s;
endpackage : rx_router_pkg

// File: logic/rx_packet_router.sv
`timescale 1ns/100ps
`include "rx_router_regs.svh"
module rx_packet_router
  import rx_router_pkg::*;
#(
  parameter int ADDR_W = 48
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // axi4-lite write address / data / response
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [11:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read address / data
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [11:0] araddr_i,
  input wire logic [2:0] arprot_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // receive side
  input wire rx_pkt_s rx_pkt_i,
  input wire iso_trailer_s iso_trailer_i,
  input wire logic dv_mode_i,
  input wire logic dv_frame_pulse_i,
  // decisions and controls
  output route_s route_o,
  output logic dv_empty_reset_o,
  output logic continuity_check_en_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (ADDR_W != 48) begin : g_bad_addr_w
    $error("rx_packet_router: ADDR_W must be 48");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] iso_trailer;
    logic [31:0] route_ctrl;
    logic cont_en; // continuity checking on; the write-only bit clears it
    logic [31:0] thr_lo;
    logic [15:0] thr_hi;
    logic [`IRQ_BITS-1:0] irq_status;
    logic [`IRQ_BITS-1:0] irq_enable;
    logic irq;
    logic fp_prev;
    logic dv_reset;
    route_s route;
  } state_s;

  state_s q; // registered state
  state_s d; // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a write onto an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // destination of a plain asynchronous packet
  function automatic dest_e async_dest(input logic [1:0] sel, input logic bcast,
                                       input logic rom_reg, input logic req, input logic above);
    dest_e r;
    r = DEST_BULK_ASYNC;
    unique case (sel)
      2'b00: begin // split by broadcast only
        r = bcast ? DEST_BROADCAST : DEST_ASYNC_CTRL;
      end
      2'b01: begin // only rom / register-space requests split
        if (rom_reg && req) begin
          r = bcast ? DEST_BROADCAST : DEST_ASYNC_CTRL;
        end
      end
      2'b10: begin // everything to the bulk queue
        r = DEST_BULK_ASYNC;
      end
      2'b11: begin // requests at or above threshold split
        if (req && above) begin
          r = bcast ? DEST_BROADCAST : DEST_ASYNC_CTRL;
        end
      end
    endcase
    return r;
  endfunction : async_dest

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [47:0] threshold; // 48-bit destination address threshold
  logic [`IRQ_BITS-1:0] events; // event pulses this cycle
  logic [31:0] hi_merge; // threshold high word after the byte-lane merge
  logic fp_rise; // frame pulse edge

  always_comb begin
    d = q;
    events = '0;
    threshold = {q.thr_hi, q.thr_lo};
    hi_merge = merge({16'h0000, q.thr_hi}, q.w_data, q.w_strb);
    fp_rise = dv_frame_pulse_i && !q.fp_prev;

    // --- write channel: address and data taken in either order
    if (awvalid_i && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr_i;
    end
    if (wvalid_i && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata_i;
      d.w_strb = wstrb_i;
    end
    // response accepted by master
    if (q.bvalid && bready_i) begin
      d.bvalid = 1'b0;
    end

    // --- perform the held write once no response is pending
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      unique case (q.aw_addr[11:2])
        `OFS_ROUTE_CTRL >> 2: begin
          // writable bits only; reserved bits stay zero
          d.route_ctrl = merge(q.route_ctrl, q.w_data, q.w_strb) & `ROUTE_CTRL_RMASK;
          // write-only bit: disables continuity checking when one
          if (q.w_strb[`POS_CONT_OFF / 8]) begin
            d.cont_en = !q.w_data[`POS_CONT_OFF];
          end
        end
        `OFS_THR_LO >> 2: begin
          d.thr_lo = merge(q.thr_lo, q.w_data, q.w_strb);
        end
        `OFS_THR_HI >> 2: begin
          // only the low half is stored; the upper half of the word is dropped on purpose
          d.thr_hi = hi_merge[15:0];
        end
        `OFS_IRQ_ENABLE >> 2: begin
          d.irq_enable = q.w_data[`IRQ_BITS-1:0];
        end
        `OFS_IRQ_CLEAR >> 2: begin
          // clear first; events below set again, so a set wins
          d.irq_status = q.irq_status & ~q.w_data[`IRQ_BITS-1:0];
        end
        `OFS_ISO_TRAILER >> 2, `OFS_IRQ_STATUS >> 2: begin
          // read-only: write ignored, answered okay
          d.bresp = `RESP_OKAY;
        end
        default: begin
          d.bresp = `RESP_SLVERR; // unmapped
        end
      endcase
    end
    // ready only while that half is not yet held and no response waits
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    // --- read channel: one read at a time
    if (q.rvalid && rready_i) begin
      d.rvalid = 1'b0;
    end
    if (arvalid_i && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      d.rdata = 32'h0000_0000;
      unique case (araddr_i[11:2])
        `OFS_ISO_TRAILER >> 2: d.rdata = q.iso_trailer;
        `OFS_ROUTE_CTRL >> 2: d.rdata = q.route_ctrl; // continuity bit reads zero
        `OFS_THR_LO >> 2: d.rdata = q.thr_lo;
        `OFS_THR_HI >> 2: d.rdata = {16'h0000, q.thr_hi};
        `OFS_IRQ_STATUS >> 2: d.rdata = {{(32-`IRQ_BITS){1'b0}}, q.irq_status};
        `OFS_IRQ_ENABLE >> 2: d.rdata = {{(32-`IRQ_BITS){1'b0}}, q.irq_enable};
        `OFS_IRQ_CLEAR >> 2: d.rdata = 32'h0000_0000; // write-only
        default: d.rresp = `RESP_SLVERR;
      endcase
    end
    d.arready = !d.rvalid;

    // --- isochronous trailer: all fields loaded together, held between packets
    if (iso_trailer_i.valid) begin
      // speed, pad count and ack code at msb-first positions
      d.iso_trailer = iso_trailer_i.quadlet & `ISO_TRAILER_MASK;
      events[`IRQ_EV_TRAILER] = 1'b1;
    end

    // --- routing and acknowledge of received packets
    d.route.valid = rx_pkt_i.valid;
    d.route.ack_valid = 1'b0;
    if (rx_pkt_i.valid) begin
      unique case (rx_pkt_i.kind)
        PKT_RESP_MATCH: begin
          d.route.dest = q.route_ctrl[`POS_RESP_DEST] ? DEST_ASYNC_CTRL : DEST_BULK_ASYNC;
        end
        PKT_SELFID: begin
          d.route.dest = q.route_ctrl[`POS_SELFID_DEST] ? DEST_BULK_ASYNC : DEST_BROADCAST;
        end
        default: begin
          d.route.dest = async_dest({q.route_ctrl[`POS_ASYNC_HI], q.route_ctrl[`POS_ASYNC_LO]},
                                    rx_pkt_i.broadcast, rx_pkt_i.rom_reg_space,
                                    rx_pkt_i.request, rx_pkt_i.dest_addr >= threshold);
        end
      endcase
      // broadcast packets are never acknowledged on the bus
      if (rx_pkt_i.kind != PKT_SELFID && !rx_pkt_i.broadcast) begin
        d.route.ack_valid = 1'b1;
        if (!rx_pkt_i.crc_ok) begin
          d.route.ack_code = `ACK_DATA_ERROR;
          events[`IRQ_EV_DATA_ERR] = 1'b1;
        end else if (rx_pkt_i.write_lock) begin
          d.route.ack_code = q.route_ctrl[`POS_ACK_PEND] ? `ACK_PENDING : `ACK_COMPLETE;
        end else begin
          d.route.ack_code = rx_pkt_i.request ? `ACK_PENDING : `ACK_COMPLETE;
        end
      end
    end

    // --- dv empty-packet insertion restart on frame pulse edge
    d.fp_prev = dv_frame_pulse_i;
    d.dv_reset = fp_rise && dv_mode_i && q.route_ctrl[`POS_FP_RESTART];
    if (d.dv_reset) begin
      events[`IRQ_EV_DV_RESET] = 1'b1;
    end

    // --- sticky status, set wins over a same-cycle clear
    d.irq_status = d.irq_status | events;
    d.irq = |(d.irq_status & d.irq_enable);
  end

  // ----------------------------------------------------------------
  // state register, synchronous active-low reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.cont_en <= 1'b1; // checking is on out of reset
      q.route_ctrl <= `ROUTE_CTRL_RESET;
      q.route.dest <= DEST_BULK_ASYNC;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign awready_o = q.awready;
  assign wready_o = q.wready;
  assign bvalid_o = q.bvalid;
  assign bresp_o = q.bresp;
  assign arready_o = q.arready;
  assign rvalid_o = q.rvalid;
  assign rdata_o = q.rdata;
  assign rresp_o = q.rresp;
  assign route_o = q.route;
  assign dv_empty_reset_o = q.dv_reset;
  assign continuity_check_en_o = q.cont_en;
  assign irq_o = q.irq;
endmodule : rx_packet_router

// File: tb/rx_phy_model.sv
`timescale 1ns/100ps
// ------
// far-side receiver: hands the router one packet descriptor per request
// ------
module rx_phy_model
  import rx_router_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request from the bench
  input wire logic send_i,
  input wire rx_pkt_s pkt_i,
  // descriptor toward the router
  output rx_pkt_s pkt_o
);
  // idle payload flips every cycle so a stale descriptor never looks fresh
  initial pkt_o = '0;
  always @(posedge clock_i) begin
    pkt_o <= send_i ? pkt_i : {1'b0, ~pkt_o[$bits(rx_pkt_s)-2:0]};
  end
endmodule : rx_phy_model

// File: tb/rx_packet_router_assertions.sv
`timescale 1ns/100ps
module rx_router_checker
  import rx_router_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  // packets and frame pulse
  input wire rx_pkt_s rx_pkt_i,
  input wire logic dv_mode_i,
  input wire logic dv_frame_pulse_i,
  input wire route_s route_o,
  input wire logic dv_empty_reset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ------
  // handshake steps
  // ------
  sequence wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence rd_taken;
    arvalid_i && arready_o;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:2] bvalid_o) else $error("write answer late");
  write_block_a: assert property (wr_taken |=> !awready_o && !wready_o) else $error("second write taken");
  read_answer_a: assert property (rd_taken |=> rvalid_o) else $error("read answer late");
  read_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o)) else $error("read data moved");
  // ------
  // routing and acknowledge
  // ------
  route_answer_a: assert property (rx_pkt_i.valid |=> route_o.valid) else $error("no route");
  route_cause_a: assert property (route_o.valid |-> $past(rx_pkt_i.valid)) else $error("stray route");
  bad_crc_ack_a: assert property (rx_pkt_i.valid && rx_pkt_i.kind == PKT_ASYNC && !rx_pkt_i.broadcast
    && !rx_pkt_i.crc_ok |=> route_o.ack_valid && route_o.ack_code == 4'hD) else $error("bad ack code");
  frame_cause_a: assert property (dv_empty_reset_o |-> $past(dv_mode_i) && $past(dv_frame_pulse_i)
    && !$past(dv_frame_pulse_i, 2)) else $error("stray empty reset");
  frame_single_a: assert property (dv_empty_reset_o |=> !dv_empty_reset_o) else $error("long empty reset");
endmodule : rx_router_checker

bind rx_packet_router rx_router_checker chk (.clock_i, .rst_n_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o,
  .bvalid_o, .arvalid_i, .arready_o, .rvalid_o, .rready_i, .rdata_o, .rx_pkt_i, .dv_mode_i, .dv_frame_pulse_i,
  .route_o, .dv_empty_reset_o);

// File: tb/test_rx_packet_router.sv
`timescale 1ns/100ps
`include "rx_router_regs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_rx_packet_router
  import rx_router_pkg::*;
;
  logic clock_i = 1'b0, rst_n_i = 1'b0, send = 1'b0, dv_mode_i = 1'b0, dv_frame_pulse_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [11:0] awaddr_i = 12'h0, araddr_i = 12'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, dv_empty_reset_o, continuity_check_en_o, irq_o;
  logic [1:0] bresp_o, rresp_o;
  rx_pkt_s pkt = '0, rx_pkt_i;
  iso_trailer_s trl = '0;
  route_s route_o;
  int bad_count = 0, samples_checked = 0, cycles = 0, pulses = 0, seed = 32'h323E32B1;
  rx_phy_model phy (.clock_i(clock_i), .send_i(send), .pkt_i(pkt), .pkt_o(rx_pkt_i));
  rx_packet_router dut (.clock_i, .rst_n_i, .awvalid_i, .awready_o, .awaddr_i, .awprot_i(3'h0), .wvalid_i,
    .wready_o, .wdata_i, .wstrb_i(4'hF), .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i,
    .arprot_i(3'h0), .rvalid_o, .rready_i, .rdata_o, .rresp_o, .rx_pkt_i, .iso_trailer_i(trl), .dv_mode_i,
    .dv_frame_pulse_i, .route_o, .dv_empty_reset_o, .continuity_check_en_o, .irq_o);
  // ------
  // clock, cycle ceiling and pulse count
  // ------
  initial forever #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    pulses += int'(dv_empty_reset_o === 1'b1);
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ------
  // bus tasks: hold each channel until its own handshake
  // ------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_i);
    awvalid_i <= 1'b1;
    awaddr_i <= a;
    wvalid_i <= 1'b1;
    wdata_i <= d;
    bready_i <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1); // only the cycle ceiling ends a hang
    bready_i <= 1'b0;
    `CHK(bresp_o, er)
  endtask : wr
  // rready waits for rvalid, so every read also exercises a stalled answer
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    arvalid_i <= 1'b1;
    araddr_i <= a;
    do begin
      @(posedge clock_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1); // only the cycle ceiling ends a hang
    rready_i <= 1'b1;
    @(posedge clock_i);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK({r, d}, {2'h0, e})
  endtask : rchk
  // packet lands in route_o when this returns
  task automatic send_pkt(input rx_pkt_s p);
    @(posedge clock_i);
    send <= 1'b1;
    pkt <= p;
    @(posedge clock_i);
    send <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask : send_pkt
  task automatic send_trl(input logic [31:0] q);
    @(posedge clock_i);
    trl <= '{1'b1, q};
    @(posedge clock_i);
    trl <= '{1'b0, ~q};
    repeat (2) @(posedge clock_i);
  endtask : send_trl
  function automatic logic [2:0] exp_dest(input logic [1:0] sel, input logic bc, rom, req, above);
    logic hit;
    hit = sel == 2'h0 || (sel == 2'h1 && rom && req) || (sel == 2'h3 && req && above);
    return !hit ? 3'b100 : (bc ? 3'b010 : 3'b001);
  endfunction : exp_dest
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ------
  // main sequence
  // ------
  initial begin
    logic [31:0] q, d;
    logic [1:0] r, sel;
    logic [47:0] adr;
    int n;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rchk(`OFS_ISO_TRAILER, 32'h0);
    rchk(`OFS_ROUTE_CTRL, 32'h0000_4400);
    `CHK(continuity_check_en_o, 1'b1)
    rd(12'h1FC, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    wr(12'h1FC, 32'hFFFF_FFFF, 2'h2);
    wr(`OFS_ISO_TRAILER, 32'hFFFF_FFFF, 2'h0);
    rchk(`OFS_ISO_TRAILER, 32'h0);
    // trailer capture, then held across an unrelated packet
    for (int i = 0; i < 8; i++) begin
      q = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      send_trl(q);
      rchk(`OFS_ISO_TRAILER, q & 32'h0003_030F);
      send_pkt('{1'b1, PKT_SELFID, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 48'h0});
      rchk(`OFS_ISO_TRAILER, q & 32'h0003_030F);
    end
    // acknowledge choice and self-id / response destinations
    for (int b = 0; b < 2; b++) begin
      wr(`OFS_ROUTE_CTRL, {17'h0, b[0], 14'h0}, 2'h0);
      send_pkt('{1'b1, PKT_ASYNC, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 48'h0});
      `CHK({route_o.ack_valid, route_o.ack_code}, {1'b1, b[0] ? 4'h2 : 4'h1})
      send_pkt('{1'b1, PKT_ASYNC, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 48'h0});
      `CHK(route_o.ack_code, 4'hD)
      wr(`OFS_ROUTE_CTRL, {20'h0, b[0], b[0], 10'h0}, 2'h0);
      send_pkt('{1'b1, PKT_SELFID, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 48'h0});
      `CHK(route_o.dest, b[0] ? 3'b100 : 3'b010)
      send_pkt('{1'b1, PKT_RESP_MATCH, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 48'h0});
      `CHK(route_o.dest, b[0] ? 3'b001 : 3'b100)
    end
    // async routing: every select, then random; pass 3 hits the threshold exactly
    wr(`OFS_THR_LO, 32'h8000_0000, 2'h0);
    wr(`OFS_THR_HI, 32'h0, 2'h0);
    for (int i = 0; i < 32; i++) begin
      d = (i == 3) ? 32'h4 : $random(seed);
      sel = (i < 4) ? i[1:0] : d[5:4];
      adr = (i == 3) ? 48'h8000_0000 : {16'h0, d};
      wr(`OFS_ROUTE_CTRL, {22'h0, sel[0], sel[1], 8'h0}, 2'h0);
      send_pkt('{1'b1, PKT_ASYNC, d[0], d[1], d[2], 1'b0, 1'b1, adr});
      `CHK(route_o.dest, exp_dest(sel, d[0], d[1], d[2], adr >= 48'h8000_0000))
    end
    wr(`OFS_ROUTE_CTRL, 32'h0000_1000, 2'h0);
    repeat (2) @(posedge clock_i);
    `CHK(continuity_check_en_o, 1'b0)
    rchk(`OFS_ROUTE_CTRL, 32'h0);
    // frame pulse: only restart bit with dv mode gives one pulse
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_ROUTE_CTRL, (i == 2) ? 32'h0 : 32'h0001_0000, 2'h0);
      dv_mode_i <= (i != 1);
      n = pulses;
      @(posedge clock_i);
      dv_frame_pulse_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      dv_frame_pulse_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      `CHK(pulses - n, (i == 0) ? 1 : 0)
    end
    // the restart writes above carried a zero in the continuity bit
    `CHK(continuity_check_en_o, 1'b1)
    // interrupt raised, cleared, then masked
    wr(`OFS_IRQ_CLEAR, 32'h7, 2'h0);
    wr(`OFS_IRQ_ENABLE, 32'h1, 2'h0);
    send_trl(32'h0);
    `CHK(irq_o, 1'b1)
    wr(`OFS_IRQ_CLEAR, 32'h1, 2'h0);
    repeat (2) @(posedge clock_i);
    `CHK(irq_o, 1'b0)
    wr(`OFS_IRQ_ENABLE, 32'h0, 2'h0);
    send_trl(32'h0);
    `CHK(irq_o, 1'b0)
    rchk(`OFS_IRQ_STATUS, 32'h1);
    report_and_stop();
  end
endmodule : test_rx_packet_router
